/* File: design/psq_pkg.sv */
package psq_pkg;

  // Clock rate and documented slot times
  localparam int CLK_MHZ = 100;
  localparam int SLOT_B_LV_MS = 6;
  localparam int SLOT_B_HV_MS = 10;
  localparam int CFG_LOAD_US = 2300;
  localparam int SLOT_DEF_US = 1000;
  localparam int STRETCH_SH = 3;
  localparam int STRETCH = 1 << STRETCH_SH;

  // Derived cycle counts; milliseconds kept apart so products stay small
  localparam int SLOT_B_LV_CYC = SLOT_B_LV_MS * 1000 * CLK_MHZ;
  localparam int SLOT_B_HV_CYC = SLOT_B_HV_MS * 1000 * CLK_MHZ;
  localparam int CFG_LOAD_CYC = CFG_LOAD_US * CLK_MHZ;
  localparam int SLOT_DEF_CYC = SLOT_DEF_US * CLK_MHZ;

  // Enable vector layout
  localparam int RAIL_SW1 = 0;
  localparam int RAIL_SW2 = 1;
  localparam int RAIL_SW3 = 2;
  localparam int RAIL_SDREG = 3;
  localparam int RAIL_REG_B = 4;
  localparam int RAIL_REG_C = 5;
  localparam int RAIL_REG_D = 6;
  localparam int SEQ_GPO = 7;
  localparam int NUM_RAILS = 7;
  localparam int NUM_EN = 8;

  // Spare output bits as written over the serial port
  localparam int SPARE_A = 0;
  localparam int SPARE_B = 1;
  localparam int SPARE_IO = 2;
  localparam int NUM_SPARE = 3;

  // Slot plan
  typedef logic [1:0] psq_slot_t;
  localparam psq_slot_t SLOT_FIRST = 2'h0;
  localparam psq_slot_t SLOT_GPO = 2'h1;
  localparam psq_slot_t SLOT_LAST = 2'h3;
  localparam logic [NUM_EN-1:0] MASK_HV [0:3] = '{8'h02, 8'h80, 8'h28, 8'h55};
  localparam logic [NUM_EN-1:0] MASK_LV [0:3] = '{8'h22, 8'h80, 8'h48, 8'h15};

  // Reset values
  localparam logic [NUM_EN-1:0] EN_RST = 8'h00;
  localparam logic [NUM_SPARE-1:0] SPARE_RST = 3'h0;
  localparam logic SD_SEL_RST = 1'b1;

  // Synchronised pin positions
  localparam int PIN_SUPPLY = 0;
  localparam int PIN_ONREQ = 1;
  localparam int PIN_SDSEL = 2;
  localparam int PIN_DISCH = 3;
  localparam int NUM_PINS = 4;

  typedef enum logic [1:0] {
    ONREQ_LEVEL = 2'b00,
    ONREQ_BUTTON = 2'b01,
    ONREQ_VSENSE = 2'b10
  } psq_onreq_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_INIT = 3'b001,
    ST_UP = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_RSTA = 3'b100,
    ST_DOWN = 3'b101
  } psq_state_e;

endpackage

/* File: design/psq_timer_if.sv */
interface psq_timer_if #(
  parameter int CNT_W = 32
);
  logic start;
  logic [CNT_W-1:0] base_cyc;
  logic [CNT_W-1:0] limit_cyc;
  logic base_done;
  logic limit_done;

  modport ctl (output start, output base_cyc, output limit_cyc, input base_done, input limit_done);
  modport tmr (input start, input base_cyc, input limit_cyc, output base_done, output limit_done);
endinterface

/* File: design/psq_slot_timer.sv */
module psq_slot_timer #(
  parameter int CNT_W = 32
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Controller side
  psq_timer_if.tmr tmr_if
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] base_r;
  logic [CNT_W-1:0] limit_r;

  // Start loads one so that a slot of N cycles ends on its Nth cycle
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_r <= '0;
    end else if (tmr_if.start) begin
      cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1};
    end else if (cnt_r != '1) begin
      cnt_r <= cnt_r + 1'b1; // Saturates, never wraps to a false done
    end
  end

  // Thresholds held for the whole slot
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      base_r <= '1;
      limit_r <= '1;
    end else if (tmr_if.start) begin
      base_r <= tmr_if.base_cyc;
      limit_r <= tmr_if.limit_cyc;
    end
  end

  assign tmr_if.base_done = (cnt_r >= base_r);
  assign tmr_if.limit_done = (cnt_r >= limit_r);

endmodule // psq_slot_timer

/* File: design/psq_power_slot_sequencer.sv */
// Function
// - Low-voltage variant drives general_output_b through the second slot, lasting 6 ms.
// - Next power-up slot starts only after the current slot's full duration.
// - 5 V variant drives general_output_a in the second slot, 10 ms, before slot three.
// - In bypass, select pin high gives 3.3 V, low gives 1.8 V.
// - A serial write can also switch the SD regulator voltage.
// - Spare outputs stay off until power-up completes, then serial writes may enable them.
// - With first-supply detect, the first power-up starts on supply even under an off request.
// - First power-up with first-supply detect treats the pin as a valid on request.
// - First-supply detect works with level, push-button and voltage-sense pin modes.
// - First power-up with first-supply detect skips the configuration-load delay.
// - 5 V variant enables the 3.3 V second switcher in the earliest slot.
// - Power-down slots may stretch up to eight times while outputs discharge.
module psq_power_slot_sequencer #(
  parameter int CNT_W = 32,
  parameter int unsigned SLOT_B_LV_CYC = psq_pkg::SLOT_B_LV_CYC,
  parameter int unsigned SLOT_B_HV_CYC = psq_pkg::SLOT_B_HV_CYC,
  parameter int unsigned CFG_LOAD_CYC = psq_pkg::CFG_LOAD_CYC,
  parameter int unsigned SLOT_DEF_CYC = psq_pkg::SLOT_DEF_CYC
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Asynchronous pins
  input wire logic supply_present_in,
  input wire logic on_request_pin_in,
  input wire logic sd_voltage_select_in,
  input wire logic outputs_discharged_in,
  // Configuration straps
  input wire logic variant_hv_in,
  input wire logic first_supply_detect_in,
  input wire logic [1:0] on_request_mode_in,
  input wire logic sd_bypass_mode_in,
  // Serial port writes
  input wire logic i2c_sd_wr_in,
  input wire logic i2c_sd_3v3_in,
  input wire logic i2c_spare_wr_in,
  input wire logic [psq_pkg::NUM_SPARE-1:0] i2c_spare_data_in,
  // Rail and pin outputs
  output logic [psq_pkg::NUM_RAILS-1:0] rail_en_out,
  output logic general_output_a_out,
  output logic general_output_b_out,
  output logic general_io_out,
  output logic sd_3v3_sel_out,
  // Processor reset and status
  output logic processor_power_on_reset_n_out,
  output logic processor_reset_out_n_out,
  output logic seq_done_out,
  output logic [2:0] state_out
);

  // Counts must be nonzero and survive the power-down stretch
  if (CNT_W < 8 || CNT_W > 32) begin : g_w_chk
    $error("CNT_W out of range");
  end
  if (SLOT_B_LV_CYC < 1 || SLOT_B_HV_CYC < 1 || CFG_LOAD_CYC < 1 || SLOT_DEF_CYC < 1) begin : g_c_chk
    $error("slot counts must be at least one");
  end
  if ((longint'(SLOT_B_HV_CYC) << psq_pkg::STRETCH_SH) >= (longint'(1) << CNT_W) ||
      (longint'(SLOT_B_LV_CYC) << psq_pkg::STRETCH_SH) >= (longint'(1) << CNT_W) ||
      (longint'(SLOT_DEF_CYC) << psq_pkg::STRETCH_SH) >= (longint'(1) << CNT_W) ||
      longint'(CFG_LOAD_CYC) >= (longint'(1) << CNT_W)) begin : g_s_chk
    $error("CNT_W too narrow for stretched slots");
  end

  localparam logic [CNT_W-1:0] LV_CYC = CNT_W'(SLOT_B_LV_CYC);
  localparam logic [CNT_W-1:0] HV_CYC = CNT_W'(SLOT_B_HV_CYC);
  localparam logic [CNT_W-1:0] LOAD_CYC = CNT_W'(CFG_LOAD_CYC);
  localparam logic [CNT_W-1:0] DEF_CYC = CNT_W'(SLOT_DEF_CYC);

  psq_pkg::psq_state_e state_r, state_nxt;
  psq_pkg::psq_slot_t slot_r, slot_nxt;
  logic go;
  logic [CNT_W-1:0] base_c;
  logic [psq_pkg::NUM_PINS-1:0] pin_raw, meta_r, sync_r;
  logic on_pin_d_r, sd_pin_d_r;
  logic cfg_hv_r, cfg_fsd_r, cfg_bypass_r;
  logic [1:0] cfg_mode_r;
  logic first_r, pb_on_r, rel_r, sd_sel_r;
  logic [psq_pkg::NUM_EN-1:0] en_r;
  logic [psq_pkg::NUM_SPARE-1:0] spare_r;
  logic supply_s, press, fsd_force, pin_on, want_on, disch_s;

  psq_timer_if #(.CNT_W(CNT_W)) tmr_if ();

  psq_slot_timer #(.CNT_W(CNT_W)) u_timer (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .tmr_if(tmr_if)
  );

  // Slot duration; only the general-output slot differs per variant
  function automatic logic [CNT_W-1:0] slot_dur(input psq_pkg::psq_slot_t s, input logic hv);
    slot_dur = (s == psq_pkg::SLOT_GPO) ? (hv ? HV_CYC : LV_CYC) : DEF_CYC;
  endfunction

  function automatic logic [psq_pkg::NUM_EN-1:0] slot_mask(input psq_pkg::psq_slot_t s,
                                                           input logic hv);
    slot_mask = hv ? psq_pkg::MASK_HV[s] : psq_pkg::MASK_LV[s];
  endfunction

  // Two-flop synchronisers, one per pin
  assign pin_raw = {outputs_discharged_in, sd_voltage_select_in, on_request_pin_in,
                    supply_present_in};
  for (genvar i = 0; i < psq_pkg::NUM_PINS; i++) begin : g_sync
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        meta_r[i] <= 1'b0;
        sync_r[i] <= 1'b0;
      end else begin
        meta_r[i] <= pin_raw[i];
        sync_r[i] <= meta_r[i];
      end
    end
  end

  // Delayed copies for edge detection, read only from the second stage
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      on_pin_d_r <= 1'b0;
      sd_pin_d_r <= 1'b0;
    end else begin
      on_pin_d_r <= sync_r[psq_pkg::PIN_ONREQ];
      sd_pin_d_r <= sync_r[psq_pkg::PIN_SDSEL];
    end
  end

  // Straps are caught while idle, so a change mid-sequence cannot tear the plan
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cfg_hv_r <= 1'b0;
      cfg_fsd_r <= 1'b0;
      cfg_bypass_r <= 1'b0;
      cfg_mode_r <= psq_pkg::ONREQ_LEVEL;
    end else if (state_r == psq_pkg::ST_IDLE) begin
      cfg_hv_r <= variant_hv_in;
      cfg_fsd_r <= first_supply_detect_in;
      cfg_bypass_r <= sd_bypass_mode_in;
      cfg_mode_r <= on_request_mode_in;
    end
  end

  // On-request decode; the forced request is independent of pin mode
  assign supply_s = sync_r[psq_pkg::PIN_SUPPLY];
  assign disch_s = sync_r[psq_pkg::PIN_DISCH];
  assign press = on_pin_d_r & ~sync_r[psq_pkg::PIN_ONREQ];
  assign fsd_force = cfg_fsd_r & first_r;
  assign pin_on = (cfg_mode_r == psq_pkg::ONREQ_BUTTON) ? pb_on_r : sync_r[psq_pkg::PIN_ONREQ];
  assign want_on = supply_s & (fsd_force | pin_on);

  // Push-button latch: each press toggles the request
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pb_on_r <= 1'b0;
    end else if (!supply_s) begin
      pb_on_r <= 1'b0;
    end else if (press) begin
      pb_on_r <= ~pb_on_r;
    end else if (fsd_force) begin
      pb_on_r <= 1'b1;
    end
  end

  // First power-up flag, dropped once the sequence completes
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      first_r <= 1'b1;
    end else if (go && state_nxt == psq_pkg::ST_ACTIVE) begin
      first_r <= 1'b0;
    end
  end

  // Sequencer next state; go restarts the slot timer
  always_comb begin
    state_nxt = state_r;
    slot_nxt = slot_r;
    go = 1'b0;
    base_c = DEF_CYC;
    case (state_r)
      psq_pkg::ST_IDLE: begin
        if (want_on) begin
          go = 1'b1;
          if (fsd_force) begin
            state_nxt = psq_pkg::ST_UP;
            slot_nxt = psq_pkg::SLOT_FIRST;
            base_c = slot_dur(psq_pkg::SLOT_FIRST, cfg_hv_r);
          end else begin
            state_nxt = psq_pkg::ST_INIT;
            base_c = LOAD_CYC;
          end
        end
      end
      psq_pkg::ST_INIT: begin
        if (!want_on) begin
          state_nxt = psq_pkg::ST_IDLE;
        end else if (tmr_if.base_done) begin
          go = 1'b1;
          state_nxt = psq_pkg::ST_UP;
          slot_nxt = psq_pkg::SLOT_FIRST;
          base_c = slot_dur(psq_pkg::SLOT_FIRST, cfg_hv_r);
        end
      end
      psq_pkg::ST_UP: begin
        if (!want_on) begin
          go = 1'b1;
          state_nxt = psq_pkg::ST_RSTA;
        end else if (tmr_if.base_done) begin
          go = 1'b1;
          if (slot_r == psq_pkg::SLOT_LAST) begin
            state_nxt = psq_pkg::ST_ACTIVE;
          end else begin
            slot_nxt = slot_r + 2'h1;
            base_c = slot_dur(slot_nxt, cfg_hv_r);
          end
        end
      end
      psq_pkg::ST_ACTIVE: begin
        if (!want_on) begin
          go = 1'b1;
          state_nxt = psq_pkg::ST_RSTA;
        end
      end
      psq_pkg::ST_RSTA: begin
        if (tmr_if.base_done) begin
          go = 1'b1;
          state_nxt = psq_pkg::ST_DOWN;
          base_c = slot_dur(slot_r, cfg_hv_r);
        end
      end
      psq_pkg::ST_DOWN: begin
        // Configured time first, then discharge or the stretch limit
        if (tmr_if.base_done && (disch_s || tmr_if.limit_done)) begin
          if (slot_r == psq_pkg::SLOT_FIRST) begin
            state_nxt = psq_pkg::ST_IDLE;
          end else begin
            go = 1'b1;
            slot_nxt = slot_r - 2'h1;
            base_c = slot_dur(slot_nxt, cfg_hv_r);
          end
        end
      end
      default: begin
        state_nxt = psq_pkg::ST_IDLE;
      end
    endcase
  end

  assign tmr_if.start = go;
  assign tmr_if.base_cyc = base_c;
  assign tmr_if.limit_cyc = base_c << psq_pkg::STRETCH_SH;

  // State and slot registers
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_r <= psq_pkg::ST_IDLE;
      slot_r <= psq_pkg::SLOT_FIRST;
    end else begin
      state_r <= state_nxt;
      slot_r <= slot_nxt;
    end
  end

  // Enables: a slot's group turns on at slot entry, off at its down slot
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      en_r <= psq_pkg::EN_RST;
    end else if (go && state_nxt == psq_pkg::ST_UP) begin
      en_r <= en_r | slot_mask(slot_nxt, cfg_hv_r);
    end else if (go && state_nxt == psq_pkg::ST_DOWN) begin
      en_r <= en_r & ~slot_mask(slot_nxt, cfg_hv_r);
    end
  end

  // Processor resets released only in the active state
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rel_r <= 1'b0;
    end else begin
      rel_r <= (state_nxt == psq_pkg::ST_ACTIVE);
    end
  end

  // Spare outputs; cleared whenever the sequence is not complete
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      spare_r <= psq_pkg::SPARE_RST;
    end else if (state_nxt != psq_pkg::ST_ACTIVE) begin
      spare_r <= psq_pkg::SPARE_RST;
    end else if (i2c_spare_wr_in && rel_r) begin
      spare_r <= i2c_spare_data_in;
    end
  end

  // SD voltage: serial write beats a pin edge in the same cycle
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sd_sel_r <= psq_pkg::SD_SEL_RST;
    end else if (!cfg_bypass_r) begin
      sd_sel_r <= psq_pkg::SD_SEL_RST;
    end else if (i2c_sd_wr_in) begin
      sd_sel_r <= i2c_sd_3v3_in;
    end else if (sd_pin_d_r != sync_r[psq_pkg::PIN_SDSEL] || state_r == psq_pkg::ST_IDLE) begin
      sd_sel_r <= sync_r[psq_pkg::PIN_SDSEL];
    end
  end

  // Sequence-owned pin depends on variant; the other stays spare
  assign rail_en_out = en_r[psq_pkg::NUM_RAILS-1:0];
  assign general_output_a_out = cfg_hv_r ? en_r[psq_pkg::SEQ_GPO] : spare_r[psq_pkg::SPARE_A];
  assign general_output_b_out = cfg_hv_r ? spare_r[psq_pkg::SPARE_B] : en_r[psq_pkg::SEQ_GPO];
  assign general_io_out = spare_r[psq_pkg::SPARE_IO];
  assign sd_3v3_sel_out = sd_sel_r;
  assign processor_power_on_reset_n_out = rel_r;
  assign processor_reset_out_n_out = rel_r;
  assign seq_done_out = rel_r;
  assign state_out = state_r;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);

  lv_gpo_slot_a: assert property ((state_r == psq_pkg::ST_UP && slot_r == psq_pkg::SLOT_GPO &&
      !cfg_hv_r) |-> general_output_b_out) else $error("slot two output b low");
  slot_hold_a: assert property ((state_r == psq_pkg::ST_UP && !tmr_if.base_done && want_on)
      |=> (state_r == psq_pkg::ST_UP && $stable(slot_r))) else $error("slot cut short");
  hv_gpo_slot_a: assert property ((state_r == psq_pkg::ST_UP && slot_r == psq_pkg::SLOT_GPO &&
      cfg_hv_r) |-> general_output_a_out) else $error("slot two output a low");
  sd_pin_follow_a: assert property ((cfg_bypass_r && !i2c_sd_wr_in &&
      sd_pin_d_r != sync_r[psq_pkg::PIN_SDSEL]) |=> (sd_3v3_sel_out == $past(sd_pin_d_r) ^ 1'b1))
      else $error("sd select ignored pin");
  sd_serial_wr_a: assert property ((cfg_bypass_r && i2c_sd_wr_in)
      |=> (sd_3v3_sel_out == $past(i2c_sd_3v3_in))) else $error("sd write lost");
  spare_off_a: assert property (!seq_done_out |-> (!general_io_out &&
      (cfg_hv_r ? !general_output_b_out : !general_output_a_out)))
      else $error("spare output before done");
  fsd_start_a: assert property ((state_r == psq_pkg::ST_IDLE && cfg_fsd_r && first_r && supply_s)
      |=> (state_r == psq_pkg::ST_UP && slot_r == psq_pkg::SLOT_FIRST))
      else $error("first supply start missed");
  hv_first_sw2_a: assert property ((state_r == psq_pkg::ST_UP && cfg_hv_r)
      |-> rail_en_out[psq_pkg::RAIL_SW2]) else $error("second switcher not first");
  down_stretch_a: assert property ((state_r == psq_pkg::ST_DOWN && !tmr_if.base_done)
      |=> (state_r == psq_pkg::ST_DOWN && $stable(slot_r))) else $error("down slot early");
  reset_first_a: assert property ((state_r == psq_pkg::ST_ACTIVE && !want_on)
      |=> (!processor_power_on_reset_n_out && $stable(rail_en_out)) [*2])
      else $error("rails dropped before reset");

  reach_active_c: cover property (state_r == psq_pkg::ST_UP ##1 state_r == psq_pkg::ST_ACTIVE);
  reach_down_c: cover property (state_r == psq_pkg::ST_RSTA ##1 state_r == psq_pkg::ST_DOWN);
  fsd_boot_c: cover property (state_r == psq_pkg::ST_IDLE && fsd_force && supply_s);
  sd_write_c: cover property (cfg_bypass_r && i2c_sd_wr_in);

endmodule // psq_power_slot_sequencer

/* File: test/psq_far_side_model.sv */
// Loads behind the rail enables: they report discharged a little after their rail set settles
module psq_far_side_model (
  // Clock
  input wire logic sys_clk_in,
  // Observed rail enables
  input wire logic [psq_pkg::NUM_RAILS-1:0] rail_en_in,
  // Heavy load mode, never reports discharged
  input wire logic slow_in,
  // Discharge flag back to the sequencer
  output logic discharged_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [psq_pkg::NUM_RAILS-1:0] last_r = 7'h00;
  logic [3:0] calm_r = 4'h0;

  // Cycles since the rail set last moved, saturating; falling edge like the bench
  always @(negedge sys_clk_in) begin
    last_r <= rail_en_in;
    if (rail_en_in != last_r) calm_r <= 4'h0;
    else if (calm_r != 4'hf) calm_r <= calm_r + 4'h1;
  end

  // A slow load holds the flag low so the sequencer must fall back on its stretch limit
  assign discharged_out = !slow_in && (calm_r >= 4'h2);
endmodule // psq_far_side_model

/* File: test/psq_power_slot_sequencer_bench.sv */
module psq_power_slot_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // Short counts keep the run small; DEF leaves room for the discharge flag to settle
  localparam int unsigned LV = 5;
  localparam int unsigned HV = 8;
  localparam int unsigned CFG = 4;
  localparam int unsigned DEF = 8;
  // Two synchroniser stages plus the edge that moves the state
  localparam int SYNC_LAT = 3;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic supply = 1'b0, onreq = 1'b0, sdsel = 1'b0, disch, hv = 1'b0, first_supply_detect = 1'b1, bypass = 1'b1;
  logic sd_wr = 1'b0, sd_3v3 = 1'b0, sp_wr = 1'b0, slow = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [2:0] sp_data = 3'h0;
  logic [6:0] rails;
  logic gpo_a, gpo_b, gio, sd_out, por_n, rst_n, done;
  logic [2:0] st;
  int mismatches = 0;
  int n_tests = 0;
  logic [31:0] lfsr = 32'h282919ce;

  // Free-running system clock
  always #5 sys_clk_in = ~sys_clk_in;

  psq_power_slot_sequencer #(.SLOT_B_LV_CYC(LV), .SLOT_B_HV_CYC(HV), .CFG_LOAD_CYC(CFG),
    .SLOT_DEF_CYC(DEF)) u_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .supply_present_in(supply), .on_request_pin_in(onreq), .sd_voltage_select_in(sdsel),
    .outputs_discharged_in(disch), .variant_hv_in(hv), .first_supply_detect_in(first_supply_detect),
    .on_request_mode_in(mode), .sd_bypass_mode_in(bypass), .i2c_sd_wr_in(sd_wr),
    .i2c_sd_3v3_in(sd_3v3), .i2c_spare_wr_in(sp_wr), .i2c_spare_data_in(sp_data),
    .rail_en_out(rails), .general_output_a_out(gpo_a), .general_output_b_out(gpo_b),
    .general_io_out(gio), .sd_3v3_sel_out(sd_out), .processor_power_on_reset_n_out(por_n),
    .processor_reset_out_n_out(rst_n), .seq_done_out(done), .state_out(st));

  psq_far_side_model u_load (.sys_clk_in(sys_clk_in), .rail_en_in(rails), .slow_in(slow),
    .discharged_out(disch));

  // Pseudo-random source
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Enables expected once slots 0..k have been entered; bit 7 is the sequence pin
  function automatic logic [7:0] exp_en(input logic h, input int k);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i <= k; i++) m = m | (h ? psq_pkg::MASK_HV[i] : psq_pkg::MASK_LV[i]);
    return m;
  endfunction

  // Seen enables in the same layout
  function automatic logic [7:0] cur_en();
    return {hv ? gpo_a : gpo_b, rails};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic end_sim();
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic timeout();
    mismatches++;
    $display("[FAIL] t=%0t wait ran out, state=%h", $time, st);
    end_sim();
  endtask

  // Cycles until the state reads s, bounded
  task automatic wait_state(input logic [2:0] s, input int lim, output int n);
    n = 0;
    while (st !== s) begin
      @(negedge sys_clk_in);
      n++;
      if (n > lim) timeout();
    end
  endtask

  // Cycles until state or enables move, bounded past the stretch limit
  task automatic wait_change(output int n);
    logic [10:0] was;
    was = {st, cur_en()};
    n = 0;
    while ({st, cur_en()} === was) begin
      @(negedge sys_clk_in);
      n++;
      if (n > 9 * DEF) timeout();
    end
  endtask

  // Straps are settled before release so the first captured value is the wanted one
  task automatic do_reset(input logic h, input logic [1:0] m);
    sys_rst_in = 1'b1;
    supply = 1'b0;
    hv = h;
    mode = m;
    onreq = (m == 2'h1);
    repeat (4) @(negedge sys_clk_in);
    sys_rst_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
  endtask

  // Walk the four up slots from the entry cycle; a spare write in mid-sequence must bounce
  task automatic run_up(input logic h);
    int dur;
    check(cur_en(), exp_en(h, 0));
    check({por_n, rst_n, done}, 3'h0);
    onreq = 1'b1;
    for (int k = 0; k < 4; k++) begin
      dur = (k != 1) ? DEF : (h ? HV : LV);
      sp_wr = (k == 2);
      sp_data = 3'h7;
      @(negedge sys_clk_in);
      sp_wr = 1'b0;
      repeat (dur - 2) @(negedge sys_clk_in);
      check(cur_en(), exp_en(h, k));
      @(negedge sys_clk_in);
      if (k < 3) check(cur_en(), exp_en(h, k + 1));
    end
    check({st, por_n, rst_n, done}, {psq_pkg::ST_ACTIVE, 3'h7});
    check({gio, h ? gpo_b : gpo_a}, 2'h0);
  endtask

  // Spare write once powered up; the sequence-owned pin must ignore its bit
  task automatic spare_test(input logic h);
    logic [2:0] d;
    lfsr = next_rand(lfsr);
    d = lfsr[2:0];
    sp_data = d;
    sp_wr = 1'b1;
    @(negedge sys_clk_in);
    sp_wr = 1'b0;
    @(negedge sys_clk_in);
    check({gio, h ? gpo_b : gpo_a, cur_en()}, {d[2], h ? d[1] : d[0], exp_en(h, 3)});
  endtask

  // Off request: resets first, then slots unwind in reverse, each within its stretch limit
  task automatic run_down(input logic h, input logic s);
    int n, d;
    slow = s;
    onreq = 1'b0;
    wait_state(psq_pkg::ST_RSTA, 5, n);
    check({por_n, rst_n, done, cur_en()}, {3'h0, exp_en(h, 3)});
    wait_state(psq_pkg::ST_DOWN, DEF + 1, n);
    check(n, DEF);
    for (int k = 3; k >= 0; k--) begin
      // General-output slot keeps its own variant length on the way down too
      d = (k == 1) ? (h ? HV : LV) : DEF;
      check(cur_en(), (k > 0) ? exp_en(h, k - 1) : 8'h00);
      wait_change(n);
      check(n >= (s ? 8 * d : d) && n <= (s ? 8 * d : d) + 2, 1'b1);
    end
    check(st, psq_pkg::ST_IDLE);
  endtask

  initial begin : main
    int n;
    // First-supply start under an off pin in every pin mode, level mode left running
    for (int m = 2; m >= 0; m--) begin
      lfsr = next_rand(lfsr);
      do_reset(lfsr[0], m[1:0]);
      supply = 1'b1;
      wait_state(psq_pkg::ST_UP, 5, n);
      check(st, psq_pkg::ST_UP);
      check(n, SYNC_LAT);
    end
    run_up(hv);
    spare_test(hv);
    // Pin toggles follow the pin; writes flip it and then restore it, so each pin edge shows
    for (int i = 0; i < 4; i++) begin
      sdsel = ~sdsel;
      repeat (5) @(negedge sys_clk_in);
      check(sd_out, sdsel);
      for (int j = 0; j < 2; j++) begin
        sd_3v3 = (j == 0) ? ~sdsel : sdsel;
        sd_wr = 1'b1;
        @(negedge sys_clk_in);
        sd_wr = 1'b0;
        @(negedge sys_clk_in);
        check(sd_out, sd_3v3);
      end
    end
    run_down(hv, 1'b0);
    // Second cycle: first-supply credit spent, other variant, load delay returns
    hv = ~hv;
    @(negedge sys_clk_in);
    onreq = 1'b1;
    wait_state(psq_pkg::ST_INIT, 5, n);
    wait_state(psq_pkg::ST_UP, CFG + 2, n);
    check(n, CFG);
    run_up(hv);
    spare_test(hv);
    run_down(hv, 1'b1);
    // Outside bypass the pin has no say; pin is low here so the fixed level shows
    bypass = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    check(sd_out, psq_pkg::SD_SEL_RST);
    end_sim();
  end
endmodule // psq_power_slot_sequencer_bench
